//--- design/pmta_top.sv
// table read and table write controller for one-time programmable program memory
`timescale 1ns/1ps
`default_nettype none
`include "pmta_regs.svh"
module pmta_top
(
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // core table operation requests
  input  wire logic                    table_read_op,
  input  wire logic                    table_write_op,
  input  wire pmta_pkg::pmta_ptr_mode_e ptr_mode,
  // core special-function writes
  input  wire logic                    ptr_upper_we,
  input  wire logic                    ptr_high_we,
  input  wire logic                    ptr_low_we,
  input  wire logic                    latch_we,
  input  wire logic [7:0]              sfr_wdata,
  input  wire logic                    long_write_enable_set,
  // pin and reset sources
  input  wire logic                    master_clear_program_pin,
  input  wire logic                    master_clear_reset,
  // terminating interrupt source
  input  wire logic                    int_enable,
  input  wire logic                    int_flag,
  input  wire logic                    int_high_prio,
  input  wire logic                    global_high_int_enable,
  input  wire logic                    peripheral_low_int_enable,
  // program memory array
  output logic [`PMTA_PTR_W-1:0]       mem_addr,
  output logic                         mem_rd,
  input  wire logic [7:0]              mem_rdata,
  output logic [15:0]                  mem_wdata,
  output logic                         mem_prog,
  // core side status
  output logic [`PMTA_PTR_W-1:0]       table_pointer,
  output logic [7:0]                   table_latch,
  output logic                         long_write_enable,
  output logic                         core_halt,
  output logic                         op_done,
  output logic [1:0]                   resume_action
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  pmta_pkg::pmta_state_e state_reg;
  pmta_pkg::pmta_state_e state_next;
  logic [`PMTA_PTR_W-1:0] ptr_reg;
  logic [7:0]             latch_reg;
  logic [7:0]             hold_reg;
  logic                   lwe_reg;
  logic [`PMTA_PTR_W-1:0] addr_reg;
  logic                   rd_reg;
  logic [15:0]            wdata_reg;
  logic                   prog_reg;
  logic                   halt_reg;
  logic                   done_reg;
  logic [1:0]             resume_reg;
  logic [`PMTA_PTR_W-1:0] access_addr;
  logic [`PMTA_PTR_W-1:0] ptr_after;
  logic                   terminate;
  pmta_pkg::pmta_resume_e resume;
  logic                   idle;
  logic                   start_read;
  logic                   start_write;
  logic                   write_odd;
  logic                   long_ok;
  pmta_ptr_step u_step
  (
    .ptr         (ptr_reg),
    .mode        (ptr_mode),
    .access_addr (access_addr),
    .ptr_after   (ptr_after)
  );
  pmta_wake u_wake
  (
    .int_enable                (int_enable),
    .int_flag                  (int_flag),
    .int_high_prio             (int_high_prio),
    .global_high_int_enable    (global_high_int_enable),
    .peripheral_low_int_enable (peripheral_low_int_enable),
    .terminate                 (terminate),
    .resume                    (resume)
  );
  ////////////////////////////////////////////////////////////////////////////
  // request decode
  assign idle        = (state_reg == pmta_pkg::PMTA_IDLE);
  assign start_read  = idle && table_read_op;
  // reads win if the core raises both in one cycle
  assign start_write = idle && table_write_op && !table_read_op;
  assign write_odd   = access_addr[`PMTA_ODD_BIT];
  // config space is read only, so no long write there
  assign long_ok     = master_clear_program_pin && lwe_reg && write_odd
                       && !access_addr[`PMTA_CFG_BIT];
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      pmta_pkg::PMTA_IDLE:
      begin
        if (start_read)
        begin
          state_next = pmta_pkg::PMTA_READ;
        end
        else if (start_write && long_ok)
        begin
          state_next = pmta_pkg::PMTA_PROG;
        end
      end
      pmta_pkg::PMTA_READ: state_next = pmta_pkg::PMTA_IDLE;
      pmta_pkg::PMTA_PROG:
      begin
        if (terminate)
        begin
          state_next = pmta_pkg::PMTA_IDLE;
        end
      end
      default: state_next = pmta_pkg::PMTA_IDLE;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////
  // sequencer; any reset also ends a long write
  always_ff @(posedge clk)
  begin
    if (!rst_n || master_clear_reset)
    begin
      state_reg <= pmta_pkg::PMTA_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // table pointer, a 6-bit upper write and two byte-wide writes plus auto update
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ptr_reg <= `PMTA_PTR_RST;
    end
    else if (start_read || start_write)
    begin
      ptr_reg <= ptr_after;
    end
    else
    begin
      if (ptr_upper_we)
      begin
        ptr_reg[21:16] <= sfr_wdata[5:0];
      end
      if (ptr_high_we)
      begin
        ptr_reg[15:8] <= sfr_wdata;
      end
      if (ptr_low_we)
      begin
        ptr_reg[7:0] <= sfr_wdata;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // table latch
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      latch_reg <= `PMTA_LATCH_RST;
    end
    else if (state_reg == pmta_pkg::PMTA_READ)
    begin
      latch_reg <= mem_rdata;
    end
    else if (latch_we && idle)
    begin
      latch_reg <= sfr_wdata;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // hidden holding register: no port reads or writes it directly
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      hold_reg <= `PMTA_HOLD_RST;
    else if (start_write && !write_odd)
      hold_reg <= latch_reg;
  end
  ////////////////////////////////////////////////////////////////////////////
  // long write enable: set only, cleared by power-on or master-clear reset
  always_ff @(posedge clk)
  begin
    if (!rst_n || master_clear_reset)
      lwe_reg <= 1'b0;
    else if (long_write_enable_set)
      lwe_reg <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // memory array drive
  always_ff @(posedge clk)
  begin
    if (!rst_n || master_clear_reset)
    begin
      addr_reg  <= `PMTA_PTR_RST;
      rd_reg    <= 1'b0;
      wdata_reg <= 16'h0000;
      prog_reg  <= 1'b0;
    end
    else
    begin
      rd_reg <= start_read;
      if (start_read || (start_write && long_ok))
      begin
        addr_reg <= access_addr;
      end
      if (start_write && long_ok)
      begin
        wdata_reg <= {latch_reg, hold_reg};
        prog_reg  <= 1'b1;
      end
      else if (prog_reg && terminate)
      begin
        prog_reg <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // core halt and completion
  always_ff @(posedge clk)
  begin
    if (!rst_n || master_clear_reset)
    begin
      halt_reg   <= 1'b0;
      done_reg   <= 1'b0;
      resume_reg <= pmta_pkg::PMTA_RESUME_NEXT;
    end
    else
    begin
      done_reg <= 1'b0;
      if (start_write && long_ok)
      begin
        halt_reg <= 1'b1;
      end
      else if (start_read)
      begin
        halt_reg <= 1'b1;
      end
      else if (state_reg == pmta_pkg::PMTA_READ)
      begin
        halt_reg <= 1'b0;
        done_reg <= 1'b1;
      end
      else if (state_reg == pmta_pkg::PMTA_PROG && terminate)
      begin
        // the flag input is never driven from here, so it stays set
        halt_reg   <= 1'b0;
        done_reg   <= 1'b1;
        resume_reg <= resume;
      end
      else if (start_write)
      begin
        done_reg <= 1'b1;
      end
    end
  end
  assign mem_addr          = addr_reg;
  assign mem_rd            = rd_reg;
  assign mem_wdata         = wdata_reg;
  assign mem_prog          = prog_reg;
  assign table_pointer     = ptr_reg;
  assign table_latch       = latch_reg;
  assign long_write_enable = lwe_reg;
  assign core_halt         = halt_reg;
  assign op_done           = done_reg;
  assign resume_action     = resume_reg;
  ////////////////////////////////////////////////////////////////////////////
  // checks
  prog_needs_gate_a : assert property (@(posedge clk) disable iff (!rst_n)
    $rose(mem_prog) |-> $past(master_clear_program_pin) && $past(lwe_reg))
    else $error("programming started without voltage or enable");
  prog_halts_a : assert property (@(posedge clk) disable iff (!rst_n)
    mem_prog |-> core_halt)
    else $error("core not halted while programming");
  even_no_prog_a : assert property (@(posedge clk) disable iff (!rst_n)
    (start_write && !write_odd) |=> !$rose(mem_prog))
    else $error("even write started programming");
  lwe_sticky_a : assert property (@(posedge clk) disable iff (!rst_n)
    (lwe_reg && !master_clear_reset) |=> lwe_reg)
    else $error("long write enable dropped");
  end_on_flag_a : assert property (@(posedge clk) disable iff (!rst_n || master_clear_reset)
    (state_reg == pmta_pkg::PMTA_PROG && int_enable && int_flag) |=> !mem_prog && !core_halt)
    else $error("long write did not end on flag");
  no_end_disabled_a : assert property (@(posedge clk) disable iff (!rst_n || master_clear_reset)
    (mem_prog && !int_enable) |=> mem_prog)
    else $error("long write ended without enabled source");
  read_loads_a : assert property (@(posedge clk) disable iff (!rst_n)
    start_read |=> ##1 (table_latch == $past(mem_rdata)) && op_done)
    else $error("table read did not load latch");
  odd_data_a : assert property (@(posedge clk) disable iff (!rst_n)
    $rose(mem_prog) |-> mem_wdata == {$past(latch_reg), $past(hold_reg)})
    else $error("block data order wrong");
endmodule : pmta_top
`default_nettype wire

//--- design/pmta_regs.svh
// register fields, reset values and timing counts of the table access block
`ifndef PMTA_REGS_SVH
`define PMTA_REGS_SVH
`define PMTA_PTR_W        22
`define PMTA_ADDR_W       21
`define PMTA_PTR_RST      22'h000000
`define PMTA_LATCH_RST    8'h00
`define PMTA_HOLD_RST     8'h00
`define PMTA_CFG_BIT      21
`define PMTA_ODD_BIT      0
`define PMTA_RD_LAT       2'h1
`endif

//--- design/pmta_pkg.sv
// types shared by the table access block
package pmta_pkg;
  typedef enum logic [1:0]
  {
    PMTA_PTR_KEEP = 2'h0,
    PMTA_PTR_POST_INC = 2'h1,
    PMTA_PTR_POST_DEC = 2'h2,
    PMTA_PTR_PRE_INC = 2'h3
  } pmta_ptr_mode_e;

  typedef enum logic [1:0]
  {
    PMTA_IDLE = 2'h0,
    PMTA_READ = 2'h1,
    PMTA_PROG = 2'h2
  } pmta_state_e;

  typedef enum logic [1:0]
  {
    PMTA_RESUME_NEXT = 2'h0,
    PMTA_VEC_HIGH = 2'h1,
    PMTA_VEC_LOW = 2'h2
  } pmta_resume_e;
endpackage : pmta_pkg

//--- design/pmta_ptr_step.sv
// table pointer update arithmetic
`timescale 1ns/1ps
`default_nettype none
`include "pmta_regs.svh"
module pmta_ptr_step
(
  // pointer in
  input  wire logic [`PMTA_PTR_W-1:0] ptr,
  input  wire pmta_pkg::pmta_ptr_mode_e mode,
  // addresses out
  output logic      [`PMTA_PTR_W-1:0] access_addr,
  output logic      [`PMTA_PTR_W-1:0] ptr_after
);
  logic [`PMTA_ADDR_W-1:0] inc_low;
  logic [`PMTA_ADDR_W-1:0] dec_low;

  // the configuration-space bit never carries or borrows
  assign inc_low = ptr[`PMTA_ADDR_W-1:0] + 21'h000001;
  assign dec_low = ptr[`PMTA_ADDR_W-1:0] - 21'h000001;

  always_comb
  begin
    access_addr = ptr;
    ptr_after   = ptr;
    case (mode)
      pmta_pkg::PMTA_PTR_POST_INC: ptr_after = {ptr[`PMTA_CFG_BIT], inc_low};
      pmta_pkg::PMTA_PTR_POST_DEC: ptr_after = {ptr[`PMTA_CFG_BIT], dec_low};
      pmta_pkg::PMTA_PTR_PRE_INC:
      begin
        access_addr = {ptr[`PMTA_CFG_BIT], inc_low};
        ptr_after   = {ptr[`PMTA_CFG_BIT], inc_low};
      end
      default: ptr_after = ptr;
    endcase
  end
endmodule : pmta_ptr_step
`default_nettype wire

//--- design/pmta_wake.sv
// long write termination and resume decision
`timescale 1ns/1ps
`default_nettype none
module pmta_wake
(
  // interrupt source state
  input  wire logic int_enable,
  input  wire logic int_flag,
  input  wire logic int_high_prio,
  input  wire logic global_high_int_enable,
  input  wire logic peripheral_low_int_enable,
  // decision
  output logic      terminate,
  output pmta_pkg::pmta_resume_e resume
);
  // priority and global enables never block termination
  assign terminate = int_enable & int_flag;

  always_comb
  begin
    resume = pmta_pkg::PMTA_RESUME_NEXT;
    if (int_high_prio && global_high_int_enable)
    begin
      resume = pmta_pkg::PMTA_VEC_HIGH;
    end
    else if (!int_high_prio && peripheral_low_int_enable && !global_high_int_enable)
    begin
      resume = pmta_pkg::PMTA_VEC_LOW;
    end
  end
endmodule : pmta_wake
`default_nettype wire

//--- test/pmta_mem_model.sv
// program memory array model facing the table access block
`timescale 1ns/1ps
`default_nettype none
module pmta_mem_model
(
  // clock
  input  wire logic        clk,
  // array port
  input  wire logic [21:0] mem_addr,
  input  wire logic        mem_rd,
  input  wire logic [15:0] mem_wdata,
  input  wire logic        mem_prog,
  output logic      [7:0]  mem_rdata
);
  logic [7:0] arr [256];
  logic [7:0] last_reg = 8'h00;
  logic       prog_reg = 1'b0;
  initial for (int i = 0; i < 256; i++) arr[i] = 8'(i) ^ 8'hA5;
  ////////////////////////////////////////////////////////////////////////////////
  // released data lines show the inverse of the last byte, so a late sample fails
  assign mem_rdata = mem_rd ? arr[mem_addr[7:0]] : ~last_reg;
  always @(posedge clk)
  begin
    if (mem_rd) last_reg <= arr[mem_addr[7:0]];
    prog_reg <= mem_prog;
    if (mem_prog && !prog_reg)
    begin
      arr[{mem_addr[7:1], 1'b0}] <= mem_wdata[7:0];
      arr[{mem_addr[7:1], 1'b1}] <= mem_wdata[15:8];
    end
  end
endmodule : pmta_mem_model
`default_nettype wire

//--- test/pmta_tb_top.sv
// self-checking bench of the table access block
`timescale 1ns/1ps
`default_nettype none
module pmta_tb_top;
  typedef struct packed
  {
    logic [21:0] p;
    logic [1:0]  m;
    logic [21:0] a;
    logic [21:0] q;
  } pmta_row_s;
  logic clk = 1'b0, rst_n = 1'b0, table_read_op = 1'b0, table_write_op = 1'b0;
  logic ptr_upper_we = 1'b0, ptr_high_we = 1'b0, ptr_low_we = 1'b0, latch_we = 1'b0;
  logic long_write_enable_set = 1'b0, master_clear_program_pin = 1'b0;
  logic master_clear_reset = 1'b0, int_enable = 1'b0, int_flag = 1'b0;
  logic int_high_prio = 1'b0, global_high_int_enable = 1'b0;
  logic peripheral_low_int_enable = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  pmta_pkg::pmta_ptr_mode_e ptr_mode = pmta_pkg::PMTA_PTR_KEEP;
  logic [21:0] mem_addr, table_pointer;
  logic [7:0] mem_rdata, table_latch;
  logic [15:0] mem_wdata;
  logic mem_rd, mem_prog, long_write_enable, core_halt, op_done;
  logic [1:0] resume_action;
  int n_errors = 0;
  int checks_done = 0;
  // pointer boundaries sit in the last rows: wrap must spare the top bit
  pmta_row_s rows [7] = '{'{22'h000020, 2'h0, 22'h000020, 22'h000020},
    '{22'h000041, 2'h1, 22'h000041, 22'h000042}, '{22'h000080, 2'h2, 22'h000080, 22'h00007F},
    '{22'h0000FF, 2'h3, 22'h000100, 22'h000100}, '{22'h1FFFFF, 2'h1, 22'h1FFFFF, 22'h000000},
    '{22'h3FFFFF, 2'h1, 22'h3FFFFF, 22'h200000}, '{22'h200000, 2'h2, 22'h200000, 22'h3FFFFF}};
  // {high prio, high enable, low enable, resume}
  logic [4:0] combos [5] = '{5'b11001, 5'b10000, 5'b00110, 5'b00000, 5'b01100};
  pmta_top i_pmta_top (.clk, .rst_n, .table_read_op, .table_write_op, .ptr_mode,
    .ptr_upper_we, .ptr_high_we, .ptr_low_we, .latch_we, .sfr_wdata, .long_write_enable_set,
    .master_clear_program_pin, .master_clear_reset, .int_enable, .int_flag, .int_high_prio,
    .global_high_int_enable, .peripheral_low_int_enable, .mem_addr, .mem_rd, .mem_rdata,
    .mem_wdata, .mem_prog, .table_pointer, .table_latch, .long_write_enable, .core_halt,
    .op_done, .resume_action);
  pmta_mem_model i_pmta_mem_model (.clk, .mem_addr, .mem_rd, .mem_wdata, .mem_prog,
    .mem_rdata);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick
  task automatic check(input string what, input logic [21:0] seen, input logic [21:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic sfr(input logic [1:0] which, input logic [7:0] d);
    sfr_wdata = d;
    {ptr_upper_we, ptr_high_we, ptr_low_we, latch_we} = 4'h8 >> which;
    tick;
    // an idle edge between writes keeps each strobe to one change per step
    {ptr_upper_we, ptr_high_we, ptr_low_we, latch_we} = 4'h0;
    tick;
  endtask : sfr
  task automatic req(input logic [21:0] p, input logic is_rd, input logic [1:0] m);
    sfr(2'h0, {2'h0, p[21:16]});
    sfr(2'h1, p[15:8]);
    sfr(2'h2, p[7:0]);
    table_read_op = is_rd;
    table_write_op = !is_rd;
    ptr_mode = pmta_pkg::pmta_ptr_mode_e'(m);
    tick;
    table_read_op = 1'b0;
    table_write_op = 1'b0;
  endtask : req
  task automatic wait_done;
    int k = 0;
    while (op_done !== 1'b1 && k < 20)
    begin
      tick;
      k++;
    end
    check("op_done", op_done, 22'h1);
    tick;
  endtask : wait_done
  task automatic rd(input logic [21:0] p, input logic [1:0] m, input logic [21:0] a,
                    input logic [21:0] q);
    req(p, 1'b1, m);
    check("mem_rd", mem_rd, 22'h1);
    check("mem_addr", mem_addr, a);
    wait_done;
    check("table_latch", table_latch, a[7:0] ^ 8'hA5);
    check("table_pointer", table_pointer, q);
  endtask : rd
  task automatic short_wr(input logic [21:0] p, input logic [7:0] d);
    sfr(2'h3, d);
    req(p, 1'b0, 2'h0);
    check("mem_prog short", mem_prog, 22'h0);
    wait_done;
  endtask : short_wr
  task automatic prog_block(input logic [21:0] p, input logic [7:0] lo, input logic [7:0] hi,
                            input logic [4:0] c);
    {int_high_prio, global_high_int_enable, peripheral_low_int_enable} = c[4:2];
    short_wr(p, lo);
    sfr(2'h3, hi);
    req(p | 22'h1, 1'b0, 2'h0);
    check("mem_prog", mem_prog, 22'h1);
    check("core_halt", core_halt, 22'h1);
    check("mem_wdata", {6'h0, mem_wdata}, {6'h0, hi, lo});
    int_flag = 1'b1;
    repeat (4) tick;
    check("halt held", core_halt, 22'h1);
    int_enable = 1'b1;
    wait_done;
    check("prog end", mem_prog, 22'h0);
    check("halt end", core_halt, 22'h0);
    check("resume", resume_action, {20'h0, c[1:0]});
    int_enable = 1'b0;
    int_flag = 1'b0;
  endtask : prog_block
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////////////
  initial forever #50 clk = ~clk;
  initial
  begin
    repeat (5000) @(posedge clk);
    n_errors++;
    print_verdict;
  end
  initial
  begin
    repeat (3) tick;
    check("ptr rst", table_pointer, 22'h0);
    check("latch rst", table_latch, 22'h0);
    check("lwe rst", long_write_enable, 22'h0);
    rst_n = 1'b1;
    $display("test reset done");
    foreach (rows[i]) rd(rows[i].p, rows[i].m, rows[i].a, rows[i].q);
    $display("test reads done");
    master_clear_program_pin = 1'b1;
    short_wr(22'h000011, 8'h77);
    rd(22'h000011, 2'h0, 22'h000011, 22'h000011);
    $display("test disabled write done");
    long_write_enable_set = 1'b1;
    tick;
    long_write_enable_set = 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      prog_block(22'h000010 + 22'(2 * i), 8'h30 + 8'(i), 8'hC0 + 8'(i), combos[i]);
      req(22'h000010 + 22'(2 * i), 1'b1, 2'h1);
      wait_done;
      check("low byte", table_latch, 8'h30 + 8'(i));
      req(22'h000011 + 22'(2 * i), 1'b1, 2'h0);
      wait_done;
      check("high byte", table_latch, 8'hC0 + 8'(i));
    end
    $display("test long writes done");
    // single byte change: the even byte goes back through the latch unchanged
    req(22'h000010, 1'b1, 2'h0);
    wait_done;
    req(22'h000010, 1'b0, 2'h0);
    wait_done;
    sfr(2'h3, 8'h5A);
    req(22'h000011, 1'b0, 2'h0);
    check("rmw prog", mem_prog, 22'h1);
    int_flag = 1'b1;
    int_enable = 1'b1;
    wait_done;
    int_enable = 1'b0;
    int_flag = 1'b0;
    req(22'h000010, 1'b1, 2'h0);
    wait_done;
    check("kept byte", table_latch, 22'h30);
    req(22'h000011, 1'b1, 2'h0);
    wait_done;
    check("new byte", table_latch, 22'h5A);
    check("lwe sticky", long_write_enable, 22'h1);
    $display("test byte change done");
    master_clear_program_pin = 1'b0;
    short_wr(22'h000031, 8'h99);
    master_clear_program_pin = 1'b1;
    short_wr(22'h200031, 8'h99);
    rd(22'h000031, 2'h0, 22'h000031, 22'h000031);
    $display("test refused writes done");
    short_wr(22'h000040, 8'h12);
    sfr(2'h3, 8'h34);
    req(22'h000041, 1'b0, 2'h0);
    check("prog on", mem_prog, 22'h1);
    master_clear_reset = 1'b1;
    tick;
    master_clear_reset = 1'b0;
    check("prog reset", mem_prog, 22'h0);
    check("halt reset", core_halt, 22'h0);
    check("lwe reset", long_write_enable, 22'h0);
    // a cut write is verified by reading the location back
    req(22'h000041, 1'b1, 2'h0);
    wait_done;
    check("verify cut", table_latch, 22'h34);
    $display("test master clear done");
    print_verdict;
  end
endmodule : pmta_tb_top
`default_nettype wire
